// ===== verilog/rgtc_top.v
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rgtc_defines.vh"
module rgtc_top #(
    parameter CYC_PER_MS = `RG_TICK_MS * `RG_CLK_KHZ
) (
    input  wire        sys_clk_in,
    input  wire        rst_in,
    input  wire        button_in,
    input  wire        trig_in,
    input  wire        ser_start_in,
    input  wire        ser_stop_in,
    input  wire        image_change_in,
    input  wire        read_fail_in,
    input  wire        cand_valid_in,
    input  wire [7:0]  cand_id_in,
    input  wire        cand_same_in,
    input  wire [9:0]  cand_x0_in,
    input  wire [9:0]  cand_x1_in,
    input  wire [9:0]  cand_y0_in,
    input  wire [9:0]  cand_y1_in,
    input  wire        frame_end_in,
    input  wire [3:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [31:0] rdata_out,
    output reg         gate_open_out,
    output reg         illum_on_out,
    output reg  [7:0]  illum_level_out,
    output reg         enhanced_out,
    output reg         code_accept_out,
    output reg  [7:0]  code_id_out,
    output reg  [3:0]  state_out
);

// ----------------------------------------------------------------
// States and helpers
// ----------------------------------------------------------------
localparam ST_MAN   = 4'b0001;
localparam ST_PRES  = 4'b0010;
localparam ST_STRM  = 4'b0100;
localparam ST_HFREE = 4'b1000;

function [18:0] rg_tmr;
    input [18:0] cnt;
    input        restart;
    input        tick;
    begin
        if (restart)
            rg_tmr = 19'd0;
        else if (tick && cnt != `RG_CNT_SAT)
            rg_tmr = cnt + 19'd1;
        else
            rg_tmr = cnt;
    end
endfunction

function [10:0] rg_dist;
    input [9:0] a0;
    input [9:0] a1;
    input [9:0] c;
    reg   [10:0] s;
    begin
        s = {1'b0, a0} + {1'b0, a1};
        if (s[10:1] > c)
            rg_dist = {1'b0, s[10:1] - c};
        else
            rg_dist = {1'b0, c - s[10:1]};
    end
endfunction

function [18:0] rg_clamp;
    input [31:0] v;
    input [18:0] lim;
    begin
        if (v > {13'd0, lim})
            rg_clamp = lim;
        else
            rg_clamp = v[18:0];
    end
endfunction

// ----------------------------------------------------------------
// Pin synchronisers and millisecond tick
// ----------------------------------------------------------------
reg  [1:0]  btn_sync_reg;
reg  [1:0]  trg_sync_reg;
reg         btn_prev_reg;
reg         trg_prev_reg;
reg  [15:0] tick_cnt_reg;
reg         tick_reg;

always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        btn_sync_reg <= 2'b00;
        trg_sync_reg <= 2'b00;
        btn_prev_reg <= 1'b0;
        trg_prev_reg <= 1'b0;
        tick_cnt_reg <= 16'd0;
        tick_reg     <= 1'b0;
    end else begin
        btn_sync_reg <= {btn_sync_reg[0], button_in};
        trg_sync_reg <= {trg_sync_reg[0], trig_in};
        btn_prev_reg <= btn_sync_reg[1];
        trg_prev_reg <= trg_sync_reg[1];
        // A shared tick keeps every timer in whole milliseconds.
        if (tick_cnt_reg == CYC_PER_MS[15:0] - 16'd1) begin
            tick_cnt_reg <= 16'd0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'd1;
            tick_reg     <= 1'b0;
        end
    end
end

wire btn_lvl  = btn_sync_reg[1];
wire trg_lvl  = trg_sync_reg[1];
wire held     = btn_lvl | trg_lvl;
wire press    = (btn_lvl & ~btn_prev_reg) | (trg_lvl & ~trg_prev_reg);
wire release_ev = (~btn_lvl & btn_prev_reg) | (~trg_lvl & trg_prev_reg);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [7:0]  ctrl_reg;
reg  [18:0] read_to_reg;
reg  [18:0] hands_to_reg;
reg  [14:0] rr_cust_reg;
reg  [19:0] win_x_reg;
reg  [19:0] win_y_reg;
reg         mode_wr_reg;
wire [18:0] rr_cust_wr = rg_clamp(wdata_in, `RG_RR_MAX);

always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        ctrl_reg     <= `RG_CTRL_RST;
        read_to_reg  <= 19'd0;
        hands_to_reg <= `RG_HANDS_DEF;
        rr_cust_reg  <= 15'd0;
        win_x_reg    <= {`RG_WIN_X1, `RG_WIN_X0};
        win_y_reg    <= {`RG_WIN_Y1, `RG_WIN_Y0};
        mode_wr_reg  <= 1'b0;
    end else begin
        mode_wr_reg <= wr_in && addr_in == `RG_A_CTRL;
        if (wr_in) begin
            case (addr_in)
                `RG_A_CTRL:     ctrl_reg     <= wdata_in[7:0];
                `RG_A_READ_TO:  read_to_reg  <= rg_clamp(wdata_in, `RG_TMAX_MS);
                `RG_A_HANDS_TO: hands_to_reg <= rg_clamp(wdata_in, `RG_TMAX_MS);
                `RG_A_RR_CUST:  rr_cust_reg  <= rr_cust_wr[14:0];
                `RG_A_WIN_X:    win_x_reg    <= {wdata_in[25:16], wdata_in[9:0]};
                `RG_A_WIN_Y:    win_y_reg    <= {wdata_in[25:16], wdata_in[9:0]};
                default:        ctrl_reg     <= ctrl_reg;
            endcase
        end
    end
end

wire [1:0] cfg_mode = ctrl_reg[`RG_C_MODE];
wire       multi    = ctrl_reg[`RG_C_MULTI];

reg [18:0] rr_lim;
always @* begin
    case (ctrl_reg[`RG_C_RRSEL])
        3'h0:           rr_lim = `RG_RR_SHORT;
        3'h1:           rr_lim = `RG_RR_MEDIUM;
        3'h2:           rr_lim = `RG_RR_LONG;
        3'h3:           rr_lim = `RG_RR_XLONG;
        `RG_RRSEL_CUST: rr_lim = {4'd0, rr_cust_reg};
        default:        rr_lim = `RG_RR_SHORT;
    endcase
end

// ----------------------------------------------------------------
// Candidate filtering and selection
// ----------------------------------------------------------------
reg  [18:0] rr_cnt_reg;
reg         best_vld_reg;
reg  [10:0] best_dist_reg;
reg  [7:0]  best_id_reg;
reg  [3:0]  state_reg;

// Partial overlap with the window is enough to accept a code.
wire in_win = cand_x1_in >= win_x_reg[9:0] && cand_x0_in <= win_x_reg[19:10]
           && cand_y1_in >= win_y_reg[9:0] && cand_y0_in <= win_y_reg[19:10];
wire center_ok = ~ctrl_reg[`RG_C_CENTER] | in_win;
wire rr_busy   = rr_cnt_reg < rr_lim;
wire suppress  = state_reg == ST_PRES && cand_same_in && rr_busy;
wire cand_ok   = cand_valid_in && gate_open_out && center_ok && !suppress;
wire [10:0] cand_dist = rg_dist(cand_x0_in, cand_x1_in, `RG_FIELD_CX)
                      + rg_dist(cand_y0_in, cand_y1_in, `RG_FIELD_CY);
wire better = !best_vld_reg || cand_dist < best_dist_reg;

reg        acc_next;
reg  [7:0] acc_id_next;
always @* begin
    acc_next    = 1'b0;
    acc_id_next = code_id_out;
    if (multi) begin
        acc_next    = cand_ok;
        acc_id_next = cand_ok ? cand_id_in : code_id_out;
    end else if (frame_end_in && best_vld_reg && gate_open_out) begin
        acc_next    = 1'b1;
        acc_id_next = best_id_reg;
    end
end

always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        best_vld_reg  <= 1'b0;
        best_dist_reg <= 11'd0;
        best_id_reg   <= 8'h00;
        rr_cnt_reg    <= `RG_CNT_SAT;
    end else begin
        if (frame_end_in) begin
            best_vld_reg <= 1'b0;
        end else if (cand_ok && better) begin
            best_vld_reg  <= 1'b1;
            best_dist_reg <= cand_dist;
            best_id_reg   <= cand_id_in;
        end
        rr_cnt_reg <= rg_tmr(rr_cnt_reg, acc_next, tick_reg);
    end
end

// ----------------------------------------------------------------
// Gate control
// ----------------------------------------------------------------
reg  [18:0] rto_cnt_reg;
reg  [18:0] hf_cnt_reg;
reg  [18:0] ill_cnt_reg;
reg         ser_open_reg;
reg         ramp_reg;
reg         hold_reg;
reg  [3:0]  state_next;
reg         gate_next;
reg  [7:0]  lvl_next;

wire rto_exp = ser_open_reg && read_to_reg != 19'd0 && rto_cnt_reg >= read_to_reg;
wire hf_exp  = !held && hf_cnt_reg >= hands_to_reg;
wire ramp_step = ramp_reg && tick_reg && ill_cnt_reg >= `RG_RAMP_MS;
wire hold_exp  = hold_reg && ill_cnt_reg >= `RG_ILL_HOLD;

always @* begin
    state_next = state_reg;
    gate_next  = gate_open_out;
    lvl_next   = illum_level_out;
    if (mode_wr_reg) begin
        case (cfg_mode)
            `RG_MODE_PRES: state_next = ST_PRES;
            `RG_MODE_STRM: state_next = ST_STRM;
            default:       state_next = ST_MAN;
        endcase
        gate_next = cfg_mode != `RG_MODE_MAN;
        lvl_next  = 8'h00;
    end else begin
        case (state_reg)
            ST_MAN: begin
                // A close event wins over an open in the same cycle.
                if (ser_start_in || press)
                    gate_next = 1'b1;
                if ((acc_next && !multi) || release_ev || ser_stop_in || rto_exp)
                    gate_next = 1'b0;
                lvl_next = gate_next ? `RG_ILL_FULL : 8'h00;
            end
            ST_PRES: begin
                gate_next = 1'b1;
                if (press) begin
                    state_next = ST_HFREE;
                    lvl_next   = `RG_ILL_FULL;
                end else if (acc_next) begin
                    lvl_next = illum_level_out;
                end else if (hold_exp) begin
                    lvl_next = 8'h00;
                end else if (ramp_step && illum_level_out != `RG_ILL_FULL) begin
                    lvl_next = illum_level_out + 8'h01;
                end
            end
            ST_STRM: begin
                gate_next = 1'b1;
                lvl_next  = `RG_ILL_FULL;
            end
            ST_HFREE: begin
                gate_next = held;
                lvl_next  = held ? `RG_ILL_FULL : 8'h00;
                if (hf_exp) begin
                    state_next = ST_PRES;
                    gate_next  = 1'b1;
                    lvl_next   = 8'h00;
                end
            end
            default: begin
                state_next = ST_MAN;
                gate_next  = 1'b0;
                lvl_next   = 8'h00;
            end
        endcase
    end
end

always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        state_reg       <= ST_MAN;
        gate_open_out   <= 1'b0;
        illum_level_out <= 8'h00;
        illum_on_out    <= 1'b0;
        ser_open_reg    <= 1'b0;
        rto_cnt_reg     <= 19'd0;
        hf_cnt_reg      <= 19'd0;
        ill_cnt_reg     <= 19'd0;
        ramp_reg        <= 1'b0;
        hold_reg        <= 1'b0;
    end else begin
        state_reg       <= state_next;
        gate_open_out   <= gate_next;
        illum_level_out <= lvl_next;
        illum_on_out    <= lvl_next != 8'h00;
        if (!gate_next || state_reg != ST_MAN)
            ser_open_reg <= 1'b0;
        else if (ser_start_in)
            ser_open_reg <= 1'b1;
        rto_cnt_reg <= rg_tmr(rto_cnt_reg, ser_start_in, tick_reg);
        hf_cnt_reg  <= rg_tmr(hf_cnt_reg, held || state_reg != ST_HFREE, tick_reg);
        if (state_reg != ST_PRES || acc_next || hold_exp)
            ramp_reg <= 1'b0;
        else if (read_fail_in)
            ramp_reg <= 1'b1;
        // A fresh read restarts the hold, else the light could stay on for good.
        if (acc_next && state_reg == ST_PRES)
            hold_reg <= 1'b1;
        else if (state_reg != ST_PRES || hold_exp || image_change_in)
            hold_reg <= 1'b0;
        ill_cnt_reg <= rg_tmr(ill_cnt_reg, ramp_step || acc_next || read_fail_in, tick_reg);
    end
end

// ----------------------------------------------------------------
// Outputs and read port
// ----------------------------------------------------------------
always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        code_accept_out <= 1'b0;
        code_id_out     <= 8'h00;
        enhanced_out    <= 1'b0;
        state_out       <= ST_MAN;
        rdata_out       <= 32'h0;
    end else begin
        code_accept_out <= acc_next;
        code_id_out     <= acc_id_next;
        // Enhanced only exists for the trigger and streaming modes.
        enhanced_out    <= ctrl_reg[`RG_C_ENH] && cfg_mode != `RG_MODE_PRES;
        state_out       <= state_next;
        rdata_out       <= 32'h0;
        if (rd_in) begin
            case (addr_in)
                `RG_A_CTRL:     rdata_out <= {24'h0, ctrl_reg};
                `RG_A_READ_TO:  rdata_out <= {13'h0, read_to_reg};
                `RG_A_HANDS_TO: rdata_out <= {13'h0, hands_to_reg};
                `RG_A_RR_CUST:  rdata_out <= {17'h0, rr_cust_reg};
                `RG_A_STATUS:   rdata_out <= {16'h0, rr_busy, ser_open_reg, illum_level_out,
                                              gate_open_out, illum_on_out, state_reg};
                `RG_A_WIN_X:    rdata_out <= {6'h0, win_x_reg[19:10], 6'h0, win_x_reg[9:0]};
                `RG_A_WIN_Y:    rdata_out <= {6'h0, win_y_reg[19:10], 6'h0, win_y_reg[9:0]};
                default:        rdata_out <= 32'h0;
            endcase
        end
    end
end

endmodule
`default_nettype wire

// ===== verilog/rgtc_defines.vh
//
// Summary of operation
// - Button, input rise or start command opens gate.
// - Decode, release, input low or stop closes.
// - Serial-opened gate closes after read time-out.
// - Read time-out held in ms, 0 to 300000.
// - Presentation: gate open, ramp light after failure.
// - Presentation: light off some seconds after read.
// - Streaming: gate open, light always on.
// - Normal and enhanced variant for two modes.
// - Button or input in presentation selects trigger.
// - Then reading lasts while button or input held.
// - No trigger for hands-free time returns presentation.
// - Hands-free timer disabled in configured trigger mode.
// - Hands-free time in ms, default 5000.
// - Presentation suppresses same code within reread delay.
// - Reread presets 500, 750, 1000, 2000 ms.
// - Custom reread delay 0 to 30000 ms.
// - Multiple read keeps searching while gate open.
// - Otherwise only code nearest centre is output.
// - Field 844x640; centering accepts window codes only.
`ifndef RGTC_DEFINES_VH
`define RGTC_DEFINES_VH
`define RG_CLK_KHZ    50000
`define RG_TICK_MS    1
`define RG_TMAX_MS    19'd300000
`define RG_HANDS_DEF  19'd5000
`define RG_RR_SHORT   19'd500
`define RG_RR_MEDIUM  19'd750
`define RG_RR_LONG    19'd1000
`define RG_RR_XLONG   19'd2000
`define RG_RR_MAX     19'd30000
`define RG_ILL_HOLD   19'd3000
`define RG_RAMP_MS    19'd20
`define RG_CNT_SAT    19'h7ffff
`define RG_FIELD_CX   10'd422
`define RG_FIELD_CY   10'd320
`define RG_WIN_X0     10'd211
`define RG_WIN_X1     10'd633
`define RG_WIN_Y0     10'd160
`define RG_WIN_Y1     10'd480
`define RG_ILL_FULL   8'hff
`define RG_A_CTRL     4'h0
`define RG_A_READ_TO  4'h1
`define RG_A_HANDS_TO 4'h2
`define RG_A_RR_CUST  4'h3
`define RG_A_STATUS   4'h4
`define RG_A_WIN_X    4'h5
`define RG_A_WIN_Y    4'h6
`define RG_C_MODE     1:0
`define RG_C_ENH      2
`define RG_C_MULTI    3
`define RG_C_CENTER   4
`define RG_C_RRSEL    7:5
`define RG_CTRL_RST   8'h00
`define RG_MODE_MAN   2'h0
`define RG_MODE_PRES  2'h1
`define RG_MODE_STRM  2'h2
`define RG_RRSEL_CUST 3'h4
`endif

// ===== verif/rgtc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Checker
// ----
module rgtc_monitor #(
    parameter CYC_PER_MS = 50000
) (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        ser_start_in,
    input wire logic        ser_stop_in,
    input wire logic        cand_valid_in,
    input wire logic        frame_end_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] rdata_out,
    input wire logic        gate_open_out,
    input wire logic        illum_on_out,
    input wire logic [7:0]  illum_level_out,
    input wire logic        enhanced_out,
    input wire logic        code_accept_out,
    input wire logic [3:0]  state_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // A control write re-inits the mode two cycles later, so recent writes are excluded.
    sequence trig_s;
        state_out == 4'h1 && !wr_in && !$past(wr_in);
    endsequence
    // Close events beat an open, so no stop, candidate or frame end may coincide with the start.
    sequence calm_s;
        !ser_stop_in && !cand_valid_in && !frame_end_in;
    endsequence
    sequence pres_s;
        state_out == 4'h2 && $past(state_out) == 4'h2;
    endsequence
    open_on_start_a: assert property (ser_start_in ##0 trig_s ##0 calm_s |=> gate_open_out)
        else $error("gate stayed shut after start");
    close_on_stop_a: assert property (ser_stop_in ##0 trig_s |=> !gate_open_out)
        else $error("gate stayed open after stop");
    pres_open_a: assert property (pres_s |-> gate_open_out)
        else $error("presentation gate shut");
    pres_normal_a: assert property (pres_s |-> !enhanced_out)
        else $error("enhanced in presentation");
    stream_lit_a: assert property (state_out == 4'h4 && $past(state_out) == 4'h4
        |-> gate_open_out && illum_on_out)
        else $error("streaming gate or light off");
    hf_entry_a: assert property ($rose(state_out[3]) |-> $past(state_out) == 4'h2)
        else $error("hands-free not from presentation");
    trig_stays_a: assert property (trig_s |=> state_out == 4'h1)
        else $error("trigger mode left by itself");
    accept_cause_a: assert property (code_accept_out
        |-> $past(cand_valid_in) || $past(frame_end_in))
        else $error("accept without candidate");
    light_level_a: assert property (illum_on_out == (illum_level_out != 8'h0))
        else $error("light flag and level disagree");
    unmapped_rd_a: assert property (rd_in && addr_in > 4'h6 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind rgtc_top rgtc_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ser_start_in(ser_start_in),
    .ser_stop_in(ser_stop_in), .cand_valid_in(cand_valid_in),
    .frame_end_in(frame_end_in), .wr_in(wr_in), .rd_in(rd_in), .addr_in(addr_in),
    .rdata_out(rdata_out), .gate_open_out(gate_open_out), .illum_on_out(illum_on_out),
    .illum_level_out(illum_level_out), .enhanced_out(enhanced_out),
    .code_accept_out(code_accept_out), .state_out(state_out));
`default_nettype wire

// ===== verif/rgtc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Host terminal
// ----
module rgtc_host (
    input  wire logic sys_clk_in,
    output var logic  ser_start_out,
    output var logic  ser_stop_out
);
    initial begin
        ser_start_out = 1'b0;
        ser_stop_out = 1'b0;
    end
    // Commands arrive already decoded, one pulse each.
    task automatic send(input logic stop);
        @(posedge sys_clk_in);
        ser_start_out <= !stop;
        ser_stop_out <= stop;
        @(posedge sys_clk_in);
        ser_start_out <= 1'b0;
        ser_stop_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module tb_top;
    localparam int CPM = 5;
    logic        clk, rst, btn, trg, img, fail, cv, csame, fe, wr, rd;
    logic        gate, ill, enh, acc;
    logic [7:0]  cid, acc_id, lvl, id;
    logic [9:0]  x0, x1, y0, y1;
    logic [3:0]  addr, st;
    logic [31:0] wd, rdata, r;
    logic [39:0] near, far;
    wire         start, stop;
    int          bad_count, tests_run, i;
    rgtc_host host (.sys_clk_in(clk), .ser_start_out(start), .ser_stop_out(stop));
    rgtc_top #(.CYC_PER_MS(CPM)) uut (
        .sys_clk_in(clk), .rst_in(rst), .button_in(btn), .trig_in(trg),
        .ser_start_in(start), .ser_stop_in(stop), .image_change_in(img),
        .read_fail_in(fail), .cand_valid_in(cv), .cand_id_in(cid),
        .cand_same_in(csame), .cand_x0_in(x0), .cand_x1_in(x1), .cand_y0_in(y0),
        .cand_y1_in(y1), .frame_end_in(fe), .addr_in(addr), .wdata_in(wd),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .gate_open_out(gate),
        .illum_on_out(ill), .illum_level_out(lvl), .enhanced_out(enh),
        .code_accept_out(acc), .code_id_out(acc_id), .state_out(st));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic print_verdict;
        $display("counts run=%0d bad=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic cnd(input logic [7:0] d, input logic [39:0] b, input logic s);
        @(posedge clk);
        cv <= 1'b1;
        cid <= d;
        csame <= s;
        x0 <= b[39:30];
        x1 <= b[29:20];
        y0 <= b[19:10];
        y1 <= b[9:0];
        @(posedge clk);
        cv <= 1'b0;
        #1;
    endtask
    // A bounded wait; running out ends the run at once.
    task automatic wgate(input logic v);
        for (int k = 0; k < 40 && gate !== v; k++) begin
            cyc(1);
        end
        chk(gate, v);
        if (gate !== v) begin
            print_verdict();
        end
    endtask
    function automatic int rr_ms(input int s);
        case (s)
            0: return 500;
            1: return 750;
            2: return 1000;
            3: return 2000;
            default: return 100;
        endcase
    endfunction
    initial begin
        {rst, btn, trg, img, fail, cv, csame, fe, wr, rd} = 10'h200;
        {cid, x0, x1, y0, y1, addr, wd} = '0;
        near = {10'd400, 10'd440, 10'd300, 10'd340};
        far = {10'd0, 10'd20, 10'd0, 10'd20};
        r = $urandom(32'h1e140f5a);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h0, 32'h0);
        rd_reg(4'h1, 32'h0);
        rd_reg(4'h2, 32'd5000);
        rd_reg(4'h3, 32'h0);
        rd_reg(4'h5, {16'd633, 16'd211});
        rd_reg(4'h7, 32'h0);
        wr_reg(4'h1, 32'd400000);
        rd_reg(4'h1, 32'd300000);
        wr_reg(4'h3, 32'd40000);
        rd_reg(4'h3, 32'd30000);
        r = $urandom_range(300000);
        wr_reg(4'h2, r);
        rd_reg(4'h2, r);
        $display("test registers done");
        wr_reg(4'h1, 32'd3);
        host.send(1'b0);
        #1;
        chk(gate, 1'b1);
        cyc(9);
        chk(gate, 1'b1);
        wgate(1'b0);
        wr_reg(4'h1, 32'h0);
        for (i = 1; i < 3; i++) begin
            @(posedge clk) {trg, btn} <= i[1:0];
            wgate(1'b1);
            @(posedge clk) {trg, btn} <= 2'b00;
            wgate(1'b0);
        end
        host.send(1'b0);
        host.send(1'b1);
        #1;
        chk(gate, 1'b0);
        id = $urandom;
        host.send(1'b0);
        cnd(~id, far, 1'b0);
        cnd(id, near, 1'b0);
        @(posedge clk) fe <= 1'b1;
        @(posedge clk) fe <= 1'b0;
        #1;
        chk({acc, acc_id}, {1'b1, id});
        chk(gate, 1'b0);
        $display("test trigger done");
        wr_reg(4'h0, 32'h18);
        host.send(1'b0);
        cnd(id, far, 1'b0);
        chk(acc, 1'b0);
        cnd(~id, near, 1'b0);
        chk({acc, gate}, 2'b11);
        host.send(1'b1);
        wr_reg(4'h0, 32'h06);
        cyc(3);
        chk({st, gate, ill, enh}, 7'h27);
        chk(lvl, 8'hff);
        wr_reg(4'h0, 32'h04);
        cyc(3);
        chk(enh, 1'b1);
        $display("test modes done");
        wr_reg(4'h2, 32'd2);
        wr_reg(4'h3, rr_ms(4));
        wr_reg(4'h0, 32'h09);
        cyc(3);
        chk({st, gate, ill}, 6'h0a);
        @(posedge clk) img <= 1'b1;
        @(posedge clk) {img, fail} <= 2'b01;
        @(posedge clk) fail <= 1'b0;
        cyc(45 * CPM);
        chk(ill, 1'b1);
        chk(lvl, 8'h02);
        cnd($urandom, near, 1'b0);
        chk(acc, 1'b1);
        cyc(2900 * CPM);
        chk(ill, 1'b1);
        cyc(200 * CPM);
        chk(ill, 1'b0);
        // Each preset, then the custom value, is timed from a fresh read.
        for (i = 0; i < 5; i++) begin
            wr_reg(4'h0, {i[2:0], 5'h09});
            cnd($urandom, near, 1'b0);
            chk(acc, 1'b1);
            cyc((rr_ms(i) - 10) * CPM);
            cnd(id, near, 1'b1);
            chk(acc, 1'b0);
            cyc(20 * CPM);
            cnd(id, near, 1'b1);
            chk(acc, 1'b1);
        end
        $display("test presentation done");
        @(posedge clk) btn <= 1'b1;
        cyc(6);
        chk({st, gate}, 5'h11);
        @(posedge clk) btn <= 1'b0;
        cyc(6);
        chk({st, gate}, 5'h10);
        cyc(2 * CPM + 20);
        chk(st, 4'h2);
        wr_reg(4'h0, 32'h0);
        @(posedge clk) trg <= 1'b1;
        cyc(6);
        @(posedge clk) trg <= 1'b0;
        cyc(2 * CPM + 20);
        chk(st, 4'h1);
        $display("test hands-free done");
        print_verdict();
    end
endmodule
`default_nettype wire
